// ===== verilog/scg_pkg.sv
// Constants and types for the sleep clock gating control block.
// Assumes one system clock and byte addressing on the register bus.
package scg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int SCG_ADDR_W = 10;
  localparam logic [9:0] SCG_CLKCFG_OFS = 10'h060;
  localparam logic [9:0] SCG_RUN_OFS = 10'h104;
  localparam logic [9:0] SCG_SLEEP_OFS = 10'h114;
  localparam logic [9:0] SCG_DEEP_OFS = 10'h124;
  localparam logic [9:0] SCG_IRQ_STAT_OFS = 10'h130;
  localparam logic [9:0] SCG_IRQ_MASK_OFS = 10'h134;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SCG_GATE_MASK = 32'h030f1013;
  localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
  localparam int SCG_AUTO_GATE_BIT = 27;
  localparam logic [31:0] SCG_CLKCFG_MASK = 32'h08000000;
  localparam logic [31:0] SCG_CLKCFG_RESET = 32'h00000000;
  localparam int SCG_EV_W = 2;
  localparam int SCG_EV_FAULT = 0;
  localparam int SCG_EV_MODE = 1;
  localparam logic [1:0] SCG_RSP_OK = 2'h0;
  localparam logic [1:0] SCG_RSP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Controlled units and their gate bit positions
  // ----------------------------------------------------------------
  localparam int SCG_NUM_UNITS = 10;
  localparam int unsigned SCG_UNIT_BIT [SCG_NUM_UNITS] =
    '{0, 1, 4, 12, 16, 17, 18, 19, 24, 25};

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCG_BUS_IDLE = 2'b01,
    SCG_BUS_ACK = 2'b10
  } scg_bus_st_t;

  typedef enum logic [2:0] {
    SCG_PWR_RUN = 3'b001,
    SCG_PWR_SLEEP = 3'b010,
    SCG_PWR_DEEP = 3'b100
  } scg_pwr_t;

endpackage

// ===== verilog/scg_clk_gate.sv
// Glitch-free clock gate for one unit.
// Assumes en_i is launched from flops on the rising edge of clk_i.
`timescale 1ns/1ps
module scg_clk_gate (
  input wire logic clk_i,
  input wire logic en_i,
  output logic gclk_o
);

  logic en_lat;

  // Enable only follows while the clock is low
  always_latch begin
    if (!clk_i) begin
      en_lat <= en_i;
    end
  end

  assign gclk_o = clk_i & en_lat;

endmodule // scg_clk_gate

// ===== verilog/scg_ctrl.sv
// Sleep clock gating control: run, sleep and deep-sleep gate registers,
// gated unit clocks, unit access faults, Avalon-MM slave, interrupt.
// Assumes power state and unit requests come from logic on mclk_i.
//
// Notes on behaviour
// - In sleep, each gate bit set clocks its unit; cleared stops it.
// - Access to a unit whose clock is off raises its unit_fault_o bit one cycle later.
// - All gate bits reset to zero; register resets to all zeros.
// - Run, sleep and deep-sleep registers, same layout, chosen by state.
// - Sleep and deep-sleep registers apply only with auto gating enabled.
// - Bit 25 gates comparator b, bit 24 comparator a, read/write.
// - Bits 19 to 16 gate general counters d, c, b, a.
// - Bit 12 gates the two-wire port, bit 4 the synchronous serial port.
// - Bit 1 gates async serial b, bit 0 async serial a.
// - Reserved bits read as zero and are read-only.
`timescale 1ns/1ps
module scg_ctrl
  import scg_pkg::*;
#(
  parameter int NUM_UNITS = SCG_NUM_UNITS
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [SCG_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_i,
  input wire logic deep_sleep_i,
  input wire logic [NUM_UNITS-1:0] unit_req_i,
  output logic [NUM_UNITS-1:0] unit_fault_o,
  output logic [NUM_UNITS-1:0] unit_en_o,
  output logic [NUM_UNITS-1:0] unit_clk_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  scg_bus_st_t state, next_state;
  logic [31:0] run_gates, next_run_gates;
  logic [31:0] sleep_unit_clock_gates, next_sleep_gates;
  logic [31:0] deep_gates, next_deep_gates;
  logic [31:0] run_clock_configuration, next_clk_cfg;
  logic [SCG_EV_W-1:0] irq_status, next_irq_status;
  logic [SCG_EV_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rsp, next_rsp;
  logic [NUM_UNITS-1:0] unit_en, next_unit_en;
  logic [NUM_UNITS-1:0] fault, next_fault;
  logic irq, next_irq;

  logic req;
  logic hit;
  logic auto_clock_gating_enable;
  scg_pwr_t pwr;
  logic [31:0] sel_gates;
  logic [31:0] rd_mux;
  logic [SCG_EV_W-1:0] ev;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be,
                                           input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res & msk;
  endfunction

  // ----------------------------------------------------------------
  // Power state and gate selection
  // ----------------------------------------------------------------
  assign auto_clock_gating_enable =
    run_clock_configuration[SCG_AUTO_GATE_BIT];

  always_comb begin
    pwr = SCG_PWR_RUN;
    if (auto_clock_gating_enable && deep_sleep_i) begin
      pwr = SCG_PWR_DEEP;
    end else if (auto_clock_gating_enable && sleep_i) begin
      pwr = SCG_PWR_SLEEP;
    end
  end

  always_comb begin
    case (pwr)
      SCG_PWR_SLEEP: sel_gates = sleep_unit_clock_gates;
      SCG_PWR_DEEP: sel_gates = deep_gates;
      SCG_PWR_RUN: sel_gates = run_gates;
      default: sel_gates = run_gates;
    endcase
  end

  // ----------------------------------------------------------------
  // Per-unit enable, fault and clock gate
  // ----------------------------------------------------------------
  genvar gu;
  generate
    for (gu = 0; gu < NUM_UNITS; gu++) begin : g_unit
      assign next_unit_en[gu] = sel_gates[SCG_UNIT_BIT[gu]];
      assign next_fault[gu] = unit_req_i[gu] & ~unit_en[gu];
      scg_clk_gate u_gate (
        .clk_i (mclk_i),
        .en_i (unit_en[gu]),
        .gclk_o (unit_clk_o[gu])
      );
    end
  endgenerate

  assign ev[SCG_EV_FAULT] = |next_fault;
  assign ev[SCG_EV_MODE] = |(next_unit_en ^ unit_en);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & (state != SCG_BUS_ACK);

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h00000000;
    case (avs_address_i)
      SCG_RUN_OFS: rd_mux = run_gates;
      SCG_SLEEP_OFS: rd_mux = sleep_unit_clock_gates;
      SCG_DEEP_OFS: rd_mux = deep_gates;
      SCG_CLKCFG_OFS: rd_mux = run_clock_configuration;
      SCG_IRQ_STAT_OFS: rd_mux[SCG_EV_W-1:0] = irq_status;
      SCG_IRQ_MASK_OFS: rd_mux[SCG_EV_W-1:0] = irq_mask;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_run_gates = run_gates;
    next_sleep_gates = sleep_unit_clock_gates;
    next_deep_gates = deep_gates;
    next_clk_cfg = run_clock_configuration;
    next_irq_mask = irq_mask;
    next_rdata = rdata;
    next_rsp = rsp;
    next_irq_status = irq_status | ev;
    case (state)
      SCG_BUS_IDLE: begin
        if (req) begin
          next_state = SCG_BUS_ACK;
          next_rdata = rd_mux;
          next_rsp = hit ? SCG_RSP_OK : SCG_RSP_SLVERR;
        end
      end
      SCG_BUS_ACK: begin
        next_state = SCG_BUS_IDLE;
        if (avs_write_i) begin
          case (avs_address_i)
            SCG_RUN_OFS: next_run_gates = be_merge(run_gates,
              avs_writedata_i, avs_byteenable_i, SCG_GATE_MASK);
            SCG_SLEEP_OFS: next_sleep_gates = be_merge(
              sleep_unit_clock_gates, avs_writedata_i,
              avs_byteenable_i, SCG_GATE_MASK);
            SCG_DEEP_OFS: next_deep_gates = be_merge(deep_gates,
              avs_writedata_i, avs_byteenable_i, SCG_GATE_MASK);
            SCG_CLKCFG_OFS: next_clk_cfg = be_merge(
              run_clock_configuration, avs_writedata_i,
              avs_byteenable_i, SCG_CLKCFG_MASK);
            SCG_IRQ_MASK_OFS: next_irq_mask = SCG_EV_W'(be_merge(
              {{(32-SCG_EV_W){1'b0}}, irq_mask}, avs_writedata_i,
              avs_byteenable_i, {32{1'b1}}));
            default: ;
          endcase
        end
        // Clear only what was read; fresh events survive
        if (avs_read_i && avs_address_i == SCG_IRQ_STAT_OFS) begin
          next_irq_status = (irq_status & ~rdata[SCG_EV_W-1:0]) | ev;
        end
      end
      default: next_state = SCG_BUS_IDLE;
    endcase
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= SCG_BUS_IDLE;
      run_gates <= SCG_GATE_RESET;
      sleep_unit_clock_gates <= SCG_GATE_RESET;
      deep_gates <= SCG_GATE_RESET;
      run_clock_configuration <= SCG_CLKCFG_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      rdata <= 32'h00000000;
      rsp <= SCG_RSP_OK;
      unit_en <= '0;
      fault <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      run_gates <= next_run_gates;
      sleep_unit_clock_gates <= next_sleep_gates;
      deep_gates <= next_deep_gates;
      run_clock_configuration <= next_clk_cfg;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      rsp <= next_rsp;
      unit_en <= next_unit_en;
      fault <= next_fault;
      irq <= next_irq;
    end
  end

  assign avs_readdata_o = rdata;
  assign avs_response_o = rsp;
  assign unit_en_o = unit_en;
  assign unit_fault_o = fault;
  assign irq_o = irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_sleep_write;
    avs_write_i && !avs_waitrequest_o &&
      avs_address_i == SCG_SLEEP_OFS && avs_byteenable_i == 4'hf;
  endsequence

  sequence s_bus_first;
    req && state == SCG_BUS_IDLE;
  endsequence

  chk_reset_zero: assert property (
    $past(sys_rst_i) |-> sleep_unit_clock_gates == SCG_GATE_RESET)
    else $error("sleep gates not zero after reset");

  chk_sleep_apply: assert property (
    (auto_clock_gating_enable && sleep_i && !deep_sleep_i)
      ##1 (auto_clock_gating_enable && sleep_i && !deep_sleep_i) |->
      unit_en[0] == $past(sleep_unit_clock_gates[0]) &&
      unit_en[9] == $past(sleep_unit_clock_gates[25]))
    else $error("sleep gates not applied");

  chk_auto_off_run: assert property (
    !auto_clock_gating_enable |=>
      unit_en[4] == $past(run_gates[16]))
    else $error("sleep gates applied without auto gating");

  chk_deep_apply: assert property (
    auto_clock_gating_enable && deep_sleep_i |=>
      unit_en[3] == $past(deep_gates[12]))
    else $error("deep gates not applied");

  chk_fault_raise: assert property (
    unit_req_i[2] && !unit_en[2] |=> unit_fault_o[2] ##1 1'b1)
    else $error("gated unit access gave no fault");

  chk_fault_none: assert property (
    unit_fault_o[7] |-> !$past(unit_en[7]) && $past(unit_req_i[7]))
    else $error("fault on a clocked unit");

  chk_write_lands: assert property (
    s_sleep_write |=> sleep_unit_clock_gates ==
      ($past(avs_writedata_i) & SCG_GATE_MASK))
    else $error("sleep gate write lost or reserved bits taken");

  chk_reserved_zero: assert property (
    (sleep_unit_clock_gates & ~SCG_GATE_MASK) == 32'h00000000)
    else $error("reserved sleep bits set");

  chk_bus_wait: assert property (
    s_bus_first |-> avs_waitrequest_o ##1 (!req || !avs_waitrequest_o))
    else $error("waitrequest not exactly one cycle");

  chk_irq_level: assert property (
    irq_o == |(irq_status & irq_mask))
    else $error("interrupt level wrong");

  chk_event_sticky: assert property (
    ev[SCG_EV_FAULT] |=> irq_status[SCG_EV_FAULT])
    else $error("fault event lost from status");

  chk_stat_clear: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == SCG_IRQ_STAT_OFS &&
      rdata[SCG_EV_FAULT] && !ev[SCG_EV_FAULT] |=>
      !irq_status[SCG_EV_FAULT])
    else $error("status read did not clear fault bit");

endmodule // scg_ctrl

// ===== tb/testbench.sv
// Self-checking bench for the sleep clock gating control block.
// Assumes scg_pkg and scg_ctrl are compiled first; 200 MHz clock.
`timescale 1ns/1ps
module testbench;
  import scg_pkg::*;
  logic mclk_i, sys_rst_i, avs_read_i, avs_write_i, sleep_i, deep_sleep_i;
  logic [SCG_ADDR_W-1:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, rr, rs, rd_v;
  logic [3:0] avs_byteenable_i;
  logic [1:0] avs_response_o, rsp;
  logic [9:0] unit_req_i, unit_fault_o, unit_en_o, unit_clk_o, p, exp_en;
  logic avs_waitrequest_o, irq_o, auto_en;
  int n_errors, checks_done;

  scg_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
    .unit_req_i(unit_req_i), .unit_fault_o(unit_fault_o),
    .unit_en_o(unit_en_o), .unit_clk_o(unit_clk_o), .irq_o(irq_o));

  // ----------------------------------------------------------------
  // Clock, checks and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [9:0] to_units(input logic [31:0] r);
    logic [9:0] u;
    for (int i = 0; i < SCG_NUM_UNITS; i++) u[i] = r[SCG_UNIT_BIT[i]];
    return u;
  endfunction

  // Holds the request until waitrequest is seen low, then releases
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    logic w;
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge mclk_i);
      w = avs_waitrequest_o;
      n++;
    end while (w !== 1'b0 && n < 50);
    q = avs_readdata_o;
    rsp = avs_response_o;
    chk(w, 1'b0, "waitrequest");
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
    chk(rsp, SCG_RSP_OK, "write response");
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, e, "read data");
    chk(rsp, SCG_RSP_OK, "read response");
  endtask

  // Pulses unit requests, fault must follow for disabled units only
  task automatic fault(input logic [9:0] r, input logic [9:0] en);
    @(posedge mclk_i);
    unit_req_i <= r;
    @(posedge mclk_i);
    unit_req_i <= 10'h000;
    @(negedge mclk_i);
    chk(unit_fault_o, r & ~en, "unit fault");
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    {avs_read_i, avs_write_i, sleep_i, deep_sleep_i} = 4'h0;
    avs_address_i = 10'h000;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    unit_req_i = 10'h000;
    void'($urandom(32'hd5b4ae31));
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(SCG_SLEEP_OFS, SCG_GATE_RESET);
    rd(SCG_RUN_OFS, 32'h0);
    rd(SCG_DEEP_OFS, 32'h0);
    rd(SCG_CLKCFG_OFS, SCG_CLKCFG_RESET);
    chk(unit_en_o, 10'h000, "enables after reset");
    bus(1'b1, 10'h200, 32'hffffffff, 4'hf);
    chk(rsp, SCG_RSP_SLVERR, "unmapped write");
    bus(1'b0, 10'h200, 32'h0, 4'hf);
    chk(q, 32'h0, "unmapped read data");
    chk(rsp, SCG_RSP_SLVERR, "unmapped read response");
    wr(SCG_SLEEP_OFS, 32'hffffffff);
    rd(SCG_SLEEP_OFS, 32'h030f1013);
    wr(SCG_SLEEP_OFS, 32'h0);
    bus(1'b1, SCG_SLEEP_OFS, 32'hffffffff, 4'h1);
    rd(SCG_SLEEP_OFS, 32'h00000013);
    wr(SCG_CLKCFG_OFS, 32'hffffffff);
    rd(SCG_CLKCFG_OFS, SCG_CLKCFG_MASK);
    wr(SCG_CLKCFG_OFS, 32'h0);
    fault(10'h3ff, 10'h000);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b0, "masked interrupt");
    bus(1'b0, SCG_IRQ_STAT_OFS, 32'h0, 4'hf);
    chk(q[SCG_EV_FAULT], 1'b1, "fault status");
    wr(SCG_IRQ_MASK_OFS, 32'h3);
    rd(SCG_IRQ_MASK_OFS, 32'h3);
    wr(SCG_IRQ_MASK_OFS, 32'h1);
    fault(10'h001, 10'h000);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b1, "fault interrupt");
    bus(1'b0, SCG_IRQ_STAT_OFS, 32'h0, 4'hf);
    chk(q[SCG_EV_FAULT], 1'b1, "fault status");
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b0, "interrupt cleared");
    for (int k = 0; k < 16; k++) begin
      rr = (k == 0) ? 32'h0 : $urandom();
      rs = (k == 1) ? 32'hffffffff : $urandom();
      rd_v = $urandom();
      auto_en = (k < 2) ? 1'b1 : 1'($urandom());
      wr(SCG_RUN_OFS, rr);
      wr(SCG_SLEEP_OFS, rs);
      wr(SCG_DEEP_OFS, rd_v);
      rd(SCG_SLEEP_OFS, rs & SCG_GATE_MASK);
      wr(SCG_CLKCFG_OFS, auto_en ? SCG_CLKCFG_MASK : 32'h0);
      @(posedge mclk_i);
      sleep_i <= (k < 2) ? 1'b1 : 1'($urandom());
      deep_sleep_i <= (k < 2) ? 1'b0 : 1'($urandom());
      repeat (3) @(posedge mclk_i);
      #1;
      exp_en = (auto_en && deep_sleep_i) ? to_units(rd_v) :
        ((auto_en && sleep_i) ? to_units(rs) : to_units(rr));
      if (auto_en && deep_sleep_i)
        chk(unit_en_o, to_units(rd_v), "deep enables");
      else if (auto_en && sleep_i)
        chk(unit_en_o, to_units(rs), "sleep enables");
      else
        chk(unit_en_o, to_units(rr), "run enables");
      chk(unit_clk_o, exp_en, "clock high phase");
      @(negedge mclk_i);
      chk(unit_clk_o, 10'h000, "clock low phase");
      p = 10'($urandom());
      fault(p, exp_en);
    end
    bus(1'b0, SCG_IRQ_STAT_OFS, 32'h0, 4'hf);
    chk(q[SCG_EV_MODE], 1'b1, "enable change status");
    // Second reset in mid-run
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(SCG_SLEEP_OFS, SCG_GATE_RESET);
    chk(unit_en_o, 10'h000, "enables after second reset");
    complete_run();
  end
endmodule // testbench
